// [dmp_pkg.sv]
// dual modulus prescaler package: state codes, variants, carriers
// assumes nothing of its surroundings
package dmp_pkg;

   localparam int VAR_5_6   = 0;
   localparam int VAR_8_9   = 1;
   localparam int VAR_10_11 = 2;

   localparam int STATE_W = 4;
   // sampling state for the combined enable
   localparam logic [3:0] SAMPLE_STATE = 4'hc;
   localparam logic [3:0] RESET_STATE  = 4'hf;

   // divide-by-11 walk: 15,14,12,8,9,11,6,4,0,1,3
   localparam logic [3:0] S15 = 4'hf;
   localparam logic [3:0] S14 = 4'he;
   localparam logic [3:0] S12 = 4'hc;
   localparam logic [3:0] S8  = 4'h8;
   localparam logic [3:0] S9  = 4'h9;
   localparam logic [3:0] S11 = 4'hb;
   localparam logic [3:0] S6  = 4'h6;
   localparam logic [3:0] S4  = 4'h4;
   localparam logic [3:0] S0  = 4'h0;
   localparam logic [3:0] S1  = 4'h1;
   localparam logic [3:0] S3  = 4'h3;

   localparam int NUM_ENABLES = 5;

   typedef struct packed {
      logic gate_enable_5;
      logic gate_enable_4;
      logic gate_enable_3;
      logic gate_enable_2;
      logic gate_enable_1;
   } dmp_enables_t;

   typedef enum logic [1:0] {
      CASC_NONE = 2'h0,
      CASC_2021 = 2'h1,
      CASC_4041 = 2'h2
   } dmp_casc_t;

endpackage

// [dmp_step.sv]
// next-state lookup for the four-bit modulus core
// assumes a combinational caller
`timescale 1ns/1ps
module dmp_step
   import dmp_pkg::*;
#(
   parameter int VARIANT = VAR_10_11
)
(
   input  wire logic [3:0] state,
   input  wire logic       low_mod,
   output logic      [3:0] next_state
);

   initial
   begin
      if (VARIANT < VAR_5_6 || VARIANT > VAR_10_11)
         $error("dmp_step: unsupported variant");
   end

   // the 11 walk is the master table; shorter moduli exit it early
   always_comb
   begin
      next_state = S15;
      case (state)
         S15: next_state = S14;
         S14: next_state = S12;
         S12: next_state = S8;
         S8:  next_state = S9;
         S9:  next_state = S11;
         S11: next_state = S6;
         S6:  next_state = S4;
         S4:  next_state = S0;
         S0:  next_state = S1;
         S1:  next_state = S3;
         S3:  next_state = low_mod ? S14 : S15;
         default: next_state = S15;
      endcase
      // shorter variants re-enter the walk from a reduced set
      // 9 walk drops 6 and 4; 6 walk keeps 15,14,12,4,0,3
      if (VARIANT == VAR_8_9)
      begin
         if (state == S11)
            next_state = S0;
      end
      else if (VARIANT == VAR_5_6)
      begin
         if (state == S12)
            next_state = S4;
         else if (state == S0)
            next_state = S3;
         else if (state == S8 || state == S9 || state == S11 ||
                  state == S6 || state == S1)
            next_state = S15;
      end
   end

endmodule

// [dmp_top.sv]
// dual modulus prescaler core with optional cascade flip-flops
// assumes gate enables come from pins and are synchronised here
`timescale 1ns/1ps
module dmp_top
   import dmp_pkg::*;
#(
   parameter int        VARIANT = VAR_10_11,
   parameter dmp_casc_t CASCADE = CASC_NONE
)
(
   input  wire logic         CLK,
   input  wire logic         RST_N,
   input  wire dmp_enables_t GATE_EN,
   input  wire dmp_enables_t GATE_OPEN,
   input  wire logic [4:0]   GATE_IS_TTL,
   output logic              DIV_OUT,
   output logic [3:0]        STATE
);

   initial
   begin
      if (CASCADE != CASC_NONE && VARIANT != VAR_10_11)
         $error("dmp_top: cascade needs the 10/11 core");
   end

   logic [4:0] en_raw;
   logic [4:0] en_s1;
   logic [4:0] en_s2;
   logic [3:0] state;
   logic [3:0] core_next;
   logic       ext_ff;
   logic       ext_cnt;
   logic       mod_ctl;
   logic       low_mod;
   logic       core_low;

   // open inputs resolve by family before synchronising
   genvar g;
   generate
      for (g = 0; g < NUM_ENABLES; g++)
      begin : g_open
         assign en_raw[g] = GATE_OPEN[g] ? GATE_IS_TTL[g] : GATE_EN[g];
      end
   endgenerate

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         en_s1 <= 5'h00;
         en_s2 <= 5'h00;
      end
      else
      begin
         en_s1 <= en_raw;
         en_s2 <= en_s1;
      end
   end

   always_comb
   begin
      if (CASCADE == CASC_NONE)
         mod_ctl = |en_s2;
      else
         mod_ctl = en_s2[3] | en_s2[4];
   end

   // cascade: a set extra bit forces this pass onto the short walk, otherwise mod_ctl decides
   always_comb
   begin
      case (CASCADE)
         CASC_2021: core_low = ext_ff | mod_ctl;
         CASC_4041: core_low = ext_cnt | mod_ctl | ext_ff;
         default:   core_low = mod_ctl;
      endcase
   end

   // enable latched only at the edge in state 1100
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         low_mod <= 1'b0;
      else if (state == SAMPLE_STATE)
         low_mod <= core_low;
   end

   dmp_step #(
      .VARIANT    (VARIANT)
   ) u_step (
      .state      (state),
      .low_mod    (low_mod),
      .next_state (core_next)
   );

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         state <= RESET_STATE;
      else
         state <= core_next;
   end

   // ext_ff toggles once per core cycle, ext_cnt once per two
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         ext_ff  <= 1'b0;
         ext_cnt <= 1'b0;
      end
      else if (CASCADE != CASC_NONE && state == S3)
      begin
         ext_ff <= ~ext_ff;
         if (ext_ff)
            ext_cnt <= ~ext_cnt;
      end
   end

   // output from state bit 3: one period per modulus cycle; when cascaded, from ext_ff: one period per two
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         DIV_OUT <= 1'b0;
      else if (CASCADE == CASC_NONE)
         DIV_OUT <= state[3];
      else
         DIV_OUT <= ext_ff;
   end

   assign STATE = state;

   localparam int MOD_HI = (VARIANT == VAR_5_6) ? 6 :
                           (VARIANT == VAR_8_9) ? 9 : 11;
   logic [4:0] period;
   logic       out_d;
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         period <= 5'h00;
         out_d  <= 1'b0;
      end
      else
      begin
         out_d  <= DIV_OUT;
         period <= (DIV_OUT & ~out_d) ? 5'h01 : period + 5'h01;
      end
   end

   AST_SAMPLE_ONLY_1100: assert property (@(posedge CLK) disable iff (!RST_N)
      state != SAMPLE_STATE |=> $stable(low_mod))
      else $error("modulus latch moved outside state 1100");
   AST_LOW_ANY: assert property (@(posedge CLK) disable iff (!RST_N)
      CASCADE == CASC_NONE && state == SAMPLE_STATE && |en_s2
      |=> low_mod)
      else $error("enable high did not select low modulus");
   AST_HIGH_ALL: assert property (@(posedge CLK) disable iff (!RST_N)
      CASCADE == CASC_NONE && state == SAMPLE_STATE && en_s2 == 5'h00
      |=> !low_mod)
      else $error("all enables low did not select high modulus");
   AST_STEP_11: assert property (@(posedge CLK) disable iff (!RST_N)
      VARIANT == VAR_10_11 && state == S15 |=> state == S14 ##1
      state == S12 ##1 state == S8 ##1 state == S9)
      else $error("divide-by-11 walk broken");
   AST_SKIP15: assert property (@(posedge CLK) disable iff (!RST_N)
      VARIANT == VAR_10_11 && state == S3 && low_mod |=> state == S14)
      else $error("divide-by-10 did not skip state 15");
   AST_ALWAYS_MOVES: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(RST_N) |-> state != $past(state))
      else $error("state did not advance");
   AST_PERIOD_10: assert property (@(posedge CLK) disable iff (!RST_N)
      VARIANT == VAR_10_11 && CASCADE == CASC_NONE && state == S3 && low_mod
      |=> ##9 state == S3)
      else $error("low modulus cycle is not ten clocks");
   AST_PERIOD_11: assert property (@(posedge CLK) disable iff (!RST_N)
      VARIANT == VAR_10_11 && CASCADE == CASC_NONE && state == S3 && !low_mod
      |=> ##10 state == S3)
      else $error("high modulus cycle is not eleven clocks");
   AST_OUT_PERIOD: assert property (@(posedge CLK) disable iff (!RST_N)
      CASCADE == CASC_NONE && DIV_OUT && !out_d && period >= 5'h02
      |-> (period == MOD_HI || period == MOD_HI - 1))
      else $error("output period is not a modulus of the variant");
   AST_CASC_IGNORE: assert property (@(posedge CLK) disable iff (!RST_N)
      CASCADE != CASC_NONE |-> mod_ctl == (en_s2[3] | en_s2[4]))
      else $error("cascade control not taken from enables 4 and 5");

   COV_LOW:  cover property (@(posedge CLK) state == SAMPLE_STATE && core_low);
   COV_HIGH: cover property (@(posedge CLK) state == SAMPLE_STATE && !core_low);
   COV_OUT:  cover property (@(posedge CLK) DIV_OUT && !out_d);

endmodule

// [dmp_ctrl_model.sv]
// counter control model steering the prescaler enables
// assumes STATE is the prescaler's registered state
`timescale 1ns/1ps
module dmp_ctrl_model
   import dmp_pkg::*;
#(
   parameter bit GLITCH = 1'b0
)
(
   input  wire logic         CLK,
   input  wire logic [3:0]   STATE,
   input  wire dmp_enables_t REQ_EN,
   input  wire dmp_enables_t REQ_OPEN,
   input  wire logic [4:0]   REQ_TTL,
   output dmp_enables_t      GATE_EN,
   output dmp_enables_t      GATE_OPEN,
   output logic [4:0]        GATE_IS_TTL
);
   dmp_enables_t held;
   logic         after_sample;

   initial
   begin
      held = '0;
      after_sample = 1'b0;
      GATE_EN = '0;
      GATE_OPEN = '0;
      GATE_IS_TTL = 5'h00;
   end

   // new choice lands just after the sampling edge; with GLITCH it is inverted from state 9 until state 6
   always @(posedge CLK)
   begin
      after_sample <= (STATE == SAMPLE_STATE);
      if (after_sample)
      begin
         held <= REQ_EN;
         GATE_EN <= REQ_EN;
         GATE_OPEN <= REQ_OPEN;
         GATE_IS_TTL <= REQ_TTL;
      end
      else if (GLITCH && STATE == S9)
         GATE_EN <= ~held;
      else if (STATE == S6)
         GATE_EN <= held;
   end
endmodule

// [tb.sv]
// self-checking bench: all three variants walked against a model
// assumes the 2-ff enable synchroniser of the core
`timescale 1ns/1ps
module tb;
   import dmp_pkg::*;
   logic         CLK = 1'b0;
   logic         RST_N = 1'b0;
   logic [31:0]  rnd = 32'h5a71;
   dmp_enables_t req_en = '0;
   dmp_enables_t req_open = '0;
   logic [4:0]   req_ttl = 5'h00;
   int           fails = 0;
   int           samples_checked = 0;
   int           cycles = 0;

   always #20 CLK = ~CLK;

   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   // open ttl pin reads high, open ecl pin reads low
   function automatic logic eff_low(input logic [4:0] e, input logic [4:0] o,
                                    input logic [4:0] t);
      return |((e & ~o) | (t & o));
   endfunction

   function automatic logic [3:0] next_of(input int v, input logic [3:0] s,
                                          input logic low);
      case (s)
         4'hf: return 4'he;
         4'he: return 4'hc;
         4'hc: return (v == VAR_5_6) ? 4'h4 : 4'h8;
         4'h8: return 4'h9;
         4'h9: return 4'hb;
         4'hb: return (v == VAR_8_9) ? 4'h0 : 4'h6;
         4'h6: return 4'h4;
         4'h4: return 4'h0;
         4'h0: return (v == VAR_5_6) ? 4'h3 : 4'h1;
         4'h1: return 4'h3;
         4'h3: return low ? 4'he : 4'hf;
         default: return 4'hx;
      endcase
   endfunction

   task automatic check(input string what, input logic [3:0] exp,
                        input logic [3:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop();
      if (fails == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   for (genvar v = 0; v < 3; v++)
   begin : g
      dmp_enables_t en;
      dmp_enables_t op;
      logic [4:0]   ttl;
      logic         div;
      logic [3:0]   st;
      logic [3:0]   exp_st = 4'hf;
      logic         exp_div = 1'b0;
      logic         lat = 1'b0;
      logic         armed = 1'b0;
      dmp_ctrl_model #(.GLITCH(v == VAR_10_11)) ctl (.CLK(CLK), .STATE(st),
         .REQ_EN(req_en), .REQ_OPEN(req_open), .REQ_TTL(req_ttl),
         .GATE_EN(en), .GATE_OPEN(op), .GATE_IS_TTL(ttl));
      dmp_top #(.VARIANT(v)) dut (.CLK(CLK), .RST_N(RST_N), .GATE_EN(en),
         .GATE_OPEN(op), .GATE_IS_TTL(ttl), .DIV_OUT(div), .STATE(st));
      always @(posedge CLK)
      begin
         if (armed)
         begin
            check("state", exp_st, st);
            check("div_out", {3'h0, exp_div}, {3'h0, div});
         end
         armed <= 1'b1;
         if (st == 4'hc)
            lat <= eff_low(en, op, ttl);
         exp_st <= RST_N ? next_of(v, st, lat) : 4'hf;
         exp_div <= RST_N ? st[3] : 1'b0;
      end
   end

   // hang guard: the main run needs about 2420 cycles
   always @(posedge CLK)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fails++;
         report_and_stop();
      end
   end

   initial
   begin
      repeat (16) @(posedge CLK);
      RST_N <= 1'b1;
      for (int i = 0; i < 2400; i++)
      begin
         @(posedge CLK);
         rnd = xorshift(rnd);
         if (i < 300)
            req_en <= '0;
         else if (i < 600)
            req_en <= 5'h01 << ((i / 60) % 5);
         else if (i < 900)
         begin
            req_en <= '0;
            req_open <= 5'h1f;
            req_ttl <= (i < 750) ? 5'h00 : 5'h1f;
         end
         else
         begin
            // and-ing three draws keeps all-low choices frequent
            req_en <= rnd[4:0] & rnd[9:5] & rnd[14:10];
            req_open <= rnd[19:15] & rnd[24:20];
            req_ttl <= rnd[29:25];
         end
         if (i == 1500)
            RST_N <= 1'b0;
         if (i == 1503)
            RST_N <= 1'b1;
      end
      report_and_stop();
   end
endmodule
